// ==== src/bfm_map.svh ====
// Purpose: constants for the baseband fsk modem core
// Assumes: 200 MHz system clock
// Notes:   times are kept in their own unit, stretch and carrier cycle counts derive from them
`ifndef BFM_MAP_SVH
`define BFM_MAP_SVH
`define BFM_CLK_MHZ      200
`define BFM_PHASES       16
`define BFM_PH_W         4
`define BFM_SCR_LEN      17
`define BFM_SCR_TAP_A    12
`define BFM_SCR_TAP_B    17
`define BFM_EDGE_WIN     4'h2
`define BFM_SAMPLE_PH    4'h8
`define BFM_DAC_W        8
`define BFM_DAC_MAX      8'hff
`define BFM_DAC_MIN      8'h00
`define BFM_STRETCH_US   5000
`define BFM_DCD_HOLD_US  1000
`define BFM_WDOG_MS      30000
`define BFM_STRETCH_CYC  (`BFM_STRETCH_US * `BFM_CLK_MHZ)
`define BFM_DCD_CYC      (`BFM_DCD_HOLD_US * `BFM_CLK_MHZ)
`define BFM_WDOG_CYC     (64'd30000 * 64'd1000 * 64'd200)
`endif

// ==== src/bfm_pkg.sv ====
// Purpose: types shared by the modem core
// Assumes: nothing
// Notes:   watchdog states are one-hot
package bfm_pkg;
    typedef enum logic [2:0] {
        BFM_WD_IDLE    = 3'h1,
        BFM_WD_KEYED   = 3'h2,
        BFM_WD_EXPIRED = 3'h4
    } bfm_wdog_t;

    typedef struct packed {
        logic prev;
        logic cur;
    } bfm_bits_t;

    typedef struct packed {
        logic clk;
        logic data;
        logic ber;
        logic qual_n;
        logic dcd;
    } bfm_rxo_t;
endpackage

// ==== src/bfm_modem.sv ====
// Purpose: digital core of a 9600 bps baseband fsk packet modem
// Assumes: all i_ inputs except i_rstn are asynchronous to i_clk_sys
// Notes:   the 16x clock and the transmit clock are sampled, not used as clocks
`timescale 1ns/10ps
`include "bfm_map.svh"

// Summary of operation
// - receive slicer level passes two flip-flops
// - edge machine runs on 16x bit clock
// - recovered bit clock drives descrambler and output
// - active-low quality pulse on misplaced edges
// - recovered clock samples data and descrambler
// - self-synchronizing 17-stage descrambler
// - descrambled data out plus monitor copy
// - misplaced edges remembered for milliseconds
// - carrier one-shot retriggers only when quiet
// - carrier drops when data edges stop
// - transmit data registered then shifted in
// - 17-stage scrambler reduces low-frequency content
// - sent bit is final feedback xor
// - sixteen phase samples per transmitted bit
// - ones pair holds maximum code
// - zeros pair holds minimum code
// - one-to-zero follows falling raised cosine
// - zero-to-one follows rising raised cosine
// - keying passes through watchdog one-shot
module bfm_modem
    import bfm_pkg::*;
#(
    parameter int unsigned         P_STRETCH_CYC = `BFM_STRETCH_CYC,
    parameter int unsigned         P_DCD_CYC     = `BFM_DCD_CYC,
    parameter logic [35:0]         P_WDOG_CYC    = 36'(`BFM_WDOG_CYC)
) (
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_rstn,
    input  wire logic                  i_clk16,
    input  wire logic                  i_rx_slice,
    input  wire logic                  i_tx_clk,
    input  wire logic                  i_tx_data,
    input  wire logic                  i_ptt_req,
    output logic                       o_rx_clk,
    output logic                       o_rx_data,
    output logic                       o_ber_mon,
    output logic                       o_quality_n,
    output logic                       o_dcd,
    output logic                       o_tx_ready,
    output logic [`BFM_DAC_W-1:0]      o_dac,
    output logic                       o_ptt
);
    localparam int unsigned L = `BFM_SCR_LEN;

    // rising raised-cosine step table; the falling edge reads it mirrored
    function automatic logic [`BFM_DAC_W-1:0] rc_rise(input logic [`BFM_PH_W-1:0] ph);
        case (ph)
            4'h0:    rc_rise = 8'h01;
            4'h1:    rc_rise = 8'h05;
            4'h2:    rc_rise = 8'h0f;
            4'h3:    rc_rise = 8'h1d;
            4'h4:    rc_rise = 8'h2f;
            4'h5:    rc_rise = 8'h43;
            4'h6:    rc_rise = 8'h5a;
            4'h7:    rc_rise = 8'h73;
            4'h8:    rc_rise = 8'h8c;
            4'h9:    rc_rise = 8'ha5;
            4'ha:    rc_rise = 8'hbc;
            4'hb:    rc_rise = 8'hd0;
            4'hc:    rc_rise = 8'he2;
            4'hd:    rc_rise = 8'hf0;
            4'he:    rc_rise = 8'hfa;
            default: rc_rise = 8'hfe;
        endcase
    endfunction

    // feedback of the 1 + x^12 + x^17 polynomial, used by both ends
    function automatic logic poly_fb(input logic [L-1:0] sr);
        poly_fb = sr[`BFM_SCR_TAP_A-1] ^ sr[`BFM_SCR_TAP_B-1];
    endfunction

    // input synchronisers: only the second stage is ever read
    logic [1:0] sync_rx, sync_c16, sync_txc, sync_txd, sync_ptt;
    logic       c16_prev, txc_prev, rx_prev, rx_seen;

    // edge strobes on the sampled clocks and data; the first tick only
    // primes rx_prev, so its reset value cannot fake a data edge
    wire logic rx_s    = sync_rx[1];
    wire logic tick16  = sync_c16[1] & ~c16_prev;
    wire logic tx_rise = sync_txc[1] & ~txc_prev;
    wire logic rx_edge = tick16 & rx_seen & (rx_s ^ rx_prev);

    // two-flop synchronisers plus the previous-value flops for edges
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            sync_rx  <= 2'h0;
            sync_c16 <= 2'h0;
            sync_txc <= 2'h0;
            sync_txd <= 2'h0;
            sync_ptt <= 2'h0;
            c16_prev <= 1'b0;
            txc_prev <= 1'b0;
            rx_prev  <= 1'b0;
            rx_seen  <= 1'b0;
        end else begin
            sync_rx  <= {sync_rx[0], i_rx_slice};
            sync_c16 <= {sync_c16[0], i_clk16};
            sync_txc <= {sync_txc[0], i_tx_clk};
            sync_txd <= {sync_txd[0], i_tx_data};
            sync_ptt <= {sync_ptt[0], i_ptt_req};
            c16_prev <= sync_c16[1];
            txc_prev <= sync_txc[1];
            if (tick16) begin
                rx_prev <= sync_rx[1];
                rx_seen <= 1'b1;
            end
        end
    end

    // edge machine: edges pull the phase toward zero by one step per edge
    logic [`BFM_PH_W-1:0] phase;
    wire logic in_win     = (phase <= `BFM_EDGE_WIN) || (phase >= 4'(16 - 2));
    wire logic edge_bad   = rx_edge & ~in_win;
    wire logic edge_early = rx_edge & (phase >= `BFM_SAMPLE_PH);
    wire logic edge_late  = rx_edge & (phase != 4'h0) & (phase < `BFM_SAMPLE_PH);
    wire logic [`BFM_PH_W-1:0] next_phase = edge_early ? phase + 4'h2 :
                                            edge_late  ? phase : phase + 4'h1;
    wire logic strobe     = tick16 & (next_phase == `BFM_SAMPLE_PH) & (phase != `BFM_SAMPLE_PH);
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            phase <= 4'h0;
        end else if (tick16) begin
            phase <= next_phase;
        end
    end

    // descrambler shifts the raw sampled bit once per recovered clock
    logic [L-1:0] dsr;
    logic         rx_bit;
    wire logic    desc_bit = rx_s ^ poly_fb(dsr);
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            dsr    <= '0;
            rx_bit <= 1'b0;
        end else if (strobe) begin
            rx_bit <= rx_s;
            dsr    <= {dsr[L-2:0], rx_s};
        end
    end

    // quality stretcher and carrier one-shot; both restart from full
    logic [31:0] stretch, dcd_cnt;
    logic        rx_bit_d;
    wire logic   bit_edge   = rx_bit ^ rx_bit_d;
    wire logic   quiet      = (stretch == 32'h0);
    wire logic   dcd_retrig = bit_edge & quiet;
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            stretch  <= 32'h0;
            dcd_cnt  <= 32'h0;
            rx_bit_d <= 1'b0;
        end else begin
            rx_bit_d <= rx_bit;
            if (edge_bad) begin
                stretch <= P_STRETCH_CYC;
            end else if (!quiet) begin
                stretch <= stretch - 32'h1;
            end
            if (dcd_retrig) begin
                dcd_cnt <= P_DCD_CYC;
            end else if (dcd_cnt != 32'h0) begin
                dcd_cnt <= dcd_cnt - 32'h1;
            end
        end
    end

    // receive outputs, all from one registered bundle
    bfm_rxo_t rxo;
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            rxo <= '{clk: 1'b0, data: 1'b0, ber: 1'b0, qual_n: 1'b1, dcd: 1'b0};
        end else begin
            // between ticks next_phase looks one step ahead, so only a tick may move it
            if (tick16) begin
                rxo.clk <= (next_phase >= `BFM_SAMPLE_PH);
            end
            rxo.qual_n <= ~edge_bad;
            rxo.dcd    <= dcd_retrig | (dcd_cnt > 32'h1);
            if (strobe) begin
                rxo.data <= desc_bit;
                rxo.ber  <= desc_bit;
            end
        end
    end
    assign o_rx_clk    = rxo.clk;
    assign o_rx_data   = rxo.data;
    assign o_ber_mon   = rxo.ber;
    assign o_quality_n = rxo.qual_n;
    assign o_dcd       = rxo.dcd;

    // transmit capture: the bit waits at least one cycle before entering the scrambler
    logic [L-1:0] tsr;
    logic         tx_bit, tx_pend, tx_ready;
    wire logic    buf_in_ready;
    wire logic    scr_bit  = tx_bit ^ poly_fb(tsr);
    wire logic    buf_push = tx_pend & buf_in_ready;
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            tx_bit  <= 1'b0;
            tx_pend <= 1'b0;
            tx_ready <= 1'b1;
            tsr     <= '0;
        end else begin
            if (tx_rise & ~tx_pend) begin
                tx_bit  <= sync_txd[1];
                tx_pend <= 1'b1;
                tx_ready <= 1'b0;                  // own flop keeps the pin glitch-free
            end else if (buf_push) begin
                tx_pend <= 1'b0;
                tx_ready <= 1'b1;
            end
            if (buf_push) begin
                tsr <= {tsr[L-2:0], scr_bit};
            end
        end
    end

    // two-entry bit buffer between scrambler and waveform generator;
    // a full buffer stalls the scrambler rather than losing a bit
    logic [1:0] buf_mem;
    logic       wr_ix, rd_ix;
    logic [1:0] buf_cnt;
    logic [`BFM_PH_W-1:0] tx_phase;
    assign buf_in_ready   = (buf_cnt != 2'h2);
    wire logic buf_valid  = (buf_cnt != 2'h0);
    wire logic bit_end    = tick16 & (tx_phase == 4'(`BFM_PHASES - 1));
    wire logic buf_pop    = bit_end & buf_valid;
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            buf_mem <= 2'h0;
            wr_ix   <= 1'b0;
            rd_ix   <= 1'b0;
            buf_cnt <= 2'h0;
        end else begin
            if (buf_push) begin
                buf_mem[wr_ix] <= scr_bit;
                wr_ix          <= ~wr_ix;
            end
            if (buf_pop) begin
                rd_ix <= ~rd_ix;
            end
            buf_cnt <= buf_cnt + {1'b0, buf_push} - {1'b0, buf_pop};
        end
    end

    // waveform generator: sixteen samples per bit, paced by the 16x clock;
    // an empty buffer repeats the last bit so the level does not jump
    bfm_bits_t            wbits;
    logic [`BFM_DAC_W-1:0] dac;
    wire logic [`BFM_DAC_W-1:0] next_dac =
        (wbits == 2'b11) ? `BFM_DAC_MAX :
        (wbits == 2'b00) ? `BFM_DAC_MIN :
        (wbits == 2'b10) ? rc_rise(4'hf - tx_phase) :
                           rc_rise(tx_phase);
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            tx_phase <= 4'h0;
            wbits    <= '{prev: 1'b0, cur: 1'b0};
            dac      <= `BFM_DAC_MIN;
        end else begin
            if (tick16) begin
                tx_phase <= tx_phase + 4'h1;
            end
            if (bit_end) begin
                wbits.prev <= wbits.cur;
                wbits.cur  <= buf_valid ? buf_mem[rd_ix] : wbits.cur;
            end
            dac <= next_dac;
        end
    end
    assign o_dac      = dac;
    assign o_tx_ready = tx_ready;

    // keying watchdog; a stuck request cannot keep the transmitter on
    bfm_wdog_t   wd, next_wd;
    logic [35:0] wd_cnt;
    logic        ptt;
    wire logic   req      = sync_ptt[1];
    wire logic   wd_done  = (wd_cnt == 36'h1);
    always_comb begin
        next_wd = wd;
        case (wd)
            BFM_WD_IDLE:    if (req) next_wd = BFM_WD_KEYED;
            BFM_WD_KEYED:   if (!req) next_wd = BFM_WD_IDLE;
                            else if (wd_done) next_wd = BFM_WD_EXPIRED;
            BFM_WD_EXPIRED: if (!req) next_wd = BFM_WD_IDLE;
            default:        next_wd = BFM_WD_IDLE;
        endcase
    end
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            wd     <= BFM_WD_IDLE;
            wd_cnt <= 36'h0;
            ptt    <= 1'b0;
        end else begin
            wd     <= next_wd;
            wd_cnt <= (next_wd == BFM_WD_KEYED && wd != BFM_WD_KEYED) ? P_WDOG_CYC :
                      (wd_cnt != 36'h0) ? wd_cnt - 36'h1 : 36'h0;
            ptt    <= (next_wd == BFM_WD_KEYED);
        end
    end
    assign o_ptt = ptt;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);

    sync_two_stage_a: assert property ($past(i_rstn, 2) |-> rx_s == $past(i_rx_slice, 2))
        else $error("rx level not two stages behind the pin");
    phase_step_a: assert property (tick16 && !rx_edge |=> phase == $past(phase) + 4'h1)
        else $error("phase did not advance on a quiet tick");
    rxclk_rise_a: assert property (strobe |=> o_rx_clk)
        else $error("recovered clock low after sample point");
    quality_pulse_a: assert property (rx_edge && !in_win |=> !o_quality_n ##1 o_quality_n || edge_bad)
        else $error("quality pulse missing for misplaced edge");
    descr_out_a: assert property (strobe |=> o_rx_data == ($past(rx_s) ^ $past(dsr[11]) ^ $past(dsr[16]))
        && dsr[0] == $past(rx_s) && o_ber_mon == o_rx_data)
        else $error("descrambled bit wrong");
    stretch_hold_a: assert property (!o_quality_n |-> !quiet)
        else $error("quality pulse not remembered");
    dcd_gate_a: assert property ($rose(o_dcd) |-> $past(quiet) && $past(bit_edge))
        else $error("carrier detect rose while noisy");
    dcd_drop_a: assert property (dcd_cnt == 32'h1 && !bit_edge |=> !o_dcd)
        else $error("carrier detect held without edges");
    tx_capture_a: assert property (tx_rise && !tx_pend |=> tx_bit == $past(sync_txd[1]) && tx_pend)
        else $error("transmit bit not captured");
    scramble_a: assert property (buf_push |=> tsr[0] == ($past(tx_bit) ^ $past(tsr[11]) ^ $past(tsr[16])))
        else $error("scrambled bit wrong");
    wave_level_a: assert property (wbits == 2'b11 |=> o_dac == `BFM_DAC_MAX || $past(bit_end))
        else $error("ones pair not at full scale");
    wave_rise_a: assert property (wbits == 2'b01 && !bit_end |=> o_dac == rc_rise($past(tx_phase)))
        else $error("rising step wrong");
    wdog_expire_a: assert property (wd == BFM_WD_KEYED && wd_done && req |=> ##1 !o_ptt)
        else $error("keying outlived watchdog");
    wdog_rearm_a: assert property (wd == BFM_WD_EXPIRED && req |=> !o_ptt)
        else $error("keying came back without request drop");
    ptt_key_a: assert property (wd == BFM_WD_IDLE && req |=> o_ptt)
        else $error("keying request not passed on");
    wave_fall_a: assert property (wbits == 2'b10 |=> o_dac == rc_rise(4'hf - $past(tx_phase)))
        else $error("falling step wrong");
    wave_low_a: assert property (wbits == 2'b00 |=> o_dac == `BFM_DAC_MIN)
        else $error("zeros pair not at minimum");
    tx_phase_a: assert property (tick16 |=> tx_phase == $past(tx_phase) + 4'h1)
        else $error("transmit phase did not advance");
    txready_a: assert property (tx_rise && !tx_pend |=> !o_tx_ready)
        else $error("ready stayed high while a bit waits");
endmodule

// ==== verif/bfm_tnc.sv ====
// Purpose: packet controller model, transmit clock and data
// Assumes: bit period 16 link ticks, halved by i_fast
// Notes:   data moves on the falling edge, steady at the rise
`timescale 1ns/10ps
module bfm_tnc (
    input  wire logic i_fast,
    output logic      o_tx_clk,
    output logic      o_tx_data
);
    logic [6:0] lfsr;
    // free running clock; fast mode overruns the modem on purpose
    initial begin
        o_tx_clk = 1'b0;
        o_tx_data = 1'b0;
        lfsr = 7'h5b;
        forever begin
            #(i_fast ? 192.0 : 384.0);
            o_tx_clk = ~o_tx_clk;
        end
    end
    // pattern bit changes away from the sampling rise
    always @(negedge o_tx_clk) begin
        lfsr <= {lfsr[5:0], lfsr[6] ^ lfsr[5]};
        o_tx_data <= lfsr[6];
    end
endmodule

// ==== verif/baseband_fsk_modem_digital_tb.sv ====
// Purpose: self-checking bench for the modem core
// Assumes: transmit output looped back to the slicer input
// Notes:   short stretch, carrier and watchdog counts
`timescale 1ns/10ps
module baseband_fsk_modem_digital_tb;
    logic       clk, rstn, clk16, rx_slice, ptt_req, fast, noise;
    logic       rx_clk, rxd, ber, qual_n, dcd, tx_ready, ptt;
    logic       tx_clk, tx_data, prv;
    logic [7:0] dac;
    logic [1:0] mode;
    logic       sent[$];
    logic       got[$];
    logic [7:0] dq[$];
    int         err_count, cmp_count, cyc, qcnt, run, trmax, nbm;
    localparam logic [7:0] RC [16] = '{8'h01, 8'h05, 8'h0f, 8'h1d, 8'h2f, 8'h43, 8'h5a, 8'h73,
                                       8'h8c, 8'ha5, 8'hbc, 8'hd0, 8'he2, 8'hf0, 8'hfa, 8'hfe};
    bfm_modem #(.P_STRETCH_CYC(200), .P_DCD_CYC(2000), .P_WDOG_CYC(36'd500)) dut (
        .i_clk_sys(clk), .i_rstn(rstn), .i_clk16(clk16), .i_rx_slice(rx_slice),
        .i_tx_clk(tx_clk), .i_tx_data(tx_data), .i_ptt_req(ptt_req), .o_rx_clk(rx_clk),
        .o_rx_data(rxd), .o_ber_mon(ber), .o_quality_n(qual_n), .o_dcd(dcd),
        .o_tx_ready(tx_ready), .o_dac(dac), .o_ptt(ptt));
    bfm_tnc tnc (.i_fast(fast), .o_tx_clk(tx_clk), .o_tx_data(tx_data));
    // clocks; link tick unrelated in phase to the system clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        clk16 = 1'b0;
        #1.3;
        forever #24 clk16 = ~clk16;
    end
    // slicer source: loopback, constant high level or misplaced edges
    always @(negedge clk) begin
        if (cyc % 37 == 0)
            noise <= ~noise;
        rx_slice <= (mode == 2'h0) ? dac[7] : (mode == 2'h1) ? 1'b1 : noise;
    end
    // watchers: bits both ways, dac samples, pulses, stall length
    always @(posedge tx_clk) sent.push_back(tx_data);
    always @(posedge clk16) dq.push_back(dac);
    always @(posedge clk) begin
        cyc++;
        prv <= rx_clk;
        if (rx_clk === 1'b1 && prv === 1'b0)
            got.push_back(rxd);
        if (qual_n === 1'b0)
            qcnt++;
        if (ber !== rxd)
            nbm++;
        run = (tx_ready === 1'b0) ? run + 1 : 0;
        if (run > trmax)
            trmax = run;
        if (cyc == 60000) begin
            err_count++;
            results();
        end
    end
    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    // clean loopback: data recovered, shapes, carrier up, no stall
    task automatic t_loop();
        int lag, k, ok, hit, i, j, nr, nf, nb;
        mode = 2'h0;
        wt(3000);
        sent = {};
        got = {};
        dq = {};
        trmax = 0;
        nbm = 0;
        wt(17000);
        hit = 0;
        for (lag = 0; lag < 40; lag++) begin
            ok = 1;
            for (k = 20; k < 60; k++)
                if (got[k+lag] !== sent[k])
                    ok = 0;
            if (ok == 1)
                hit = 1;
        end
        chk("rx_bits", 8'h01, 8'(hit));
        nr = 0;
        nf = 0;
        nb = 0;
        for (i = 1; i + 16 < dq.size(); i++) begin
            if (dq[i-1] === 8'h00 && dq[i] === 8'h01) begin
                nr++;
                for (j = 0; j < 16; j++)
                    chk("rise", RC[j], dq[i+j]);
            end
            if (dq[i-1] === 8'hff && dq[i] === 8'hfe) begin
                nf++;
                for (j = 0; j < 16; j++)
                    chk("fall", RC[15-j], dq[i+j]);
            end
            if (!(dq[i] inside {8'h00, 8'hff, RC}))
                nb++;
        end
        chk("rises", 8'h01, 8'(nr > 0));
        chk("falls", 8'h01, 8'(nf > 0));
        chk("stray_dac", 8'h00, 8'(nb));
        chk("dcd_up", 8'h01, 8'(dcd));
        chk("ber_copy", 8'h00, 8'(nbm));
        chk("no_stall", 8'h01, 8'(trmax < 8));
    endtask
    // no edges at all: carrier must drop
    task automatic t_quiet();
        mode = 2'h1;
        wt(3000);
        chk("dcd_quiet", 8'h00, 8'(dcd));
    endtask
    // misplaced edges: pulses, carrier held off
    task automatic t_noise();
        mode = 2'h0;
        wt(5000);
        chk("dcd_back", 8'h01, 8'(dcd));
        qcnt = 0;
        mode = 2'h2;
        wt(3000);
        chk("quality", 8'h01, 8'(qcnt > 0));
        chk("dcd_noise", 8'h00, 8'(dcd));
    endtask
    // keying through the watchdog, expiry and rearm
    task automatic t_ptt();
        ptt_req = 1'b1;
        wt(6);
        chk("ptt_on", 8'h01, 8'(ptt));
        wt(480);
        chk("ptt_held", 8'h01, 8'(ptt));
        wt(30);
        chk("ptt_expired", 8'h00, 8'(ptt));
        wt(300);
        chk("ptt_stuck", 8'h00, 8'(ptt));
        ptt_req = 1'b0;
        wt(6);
        ptt_req = 1'b1;
        wt(6);
        chk("ptt_rearm", 8'h01, 8'(ptt));
        ptt_req = 1'b0;
        wt(6);
        chk("ptt_drop", 8'h00, 8'(ptt));
    endtask
    // overrun by a fast controller fills the buffer
    task automatic t_fast();
        trmax = 0;
        fast = 1'b1;
        wt(4000);
        chk("buf_full", 8'h01, 8'(trmax > 20));
        fast = 1'b0;
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // reset, then the scenarios in order
    initial begin
        rstn = 1'b0;
        ptt_req = 1'b0;
        fast = 1'b0;
        noise = 1'b0;
        mode = 2'h1;
        rx_slice = 1'b1;
        err_count = 0;
        cmp_count = 0;
        cyc = 0;
        wt(5);
        chk("rst_out", 8'h12, {ptt, dac[0], dcd, qual_n, rxd, ber, tx_ready, rx_clk});
        rstn = 1'b1;
        t_loop();
        t_quiet();
        t_noise();
        t_ptt();
        t_fast();
        results();
    end
endmodule
